// File: hw/tdr_decoder.sv
// Terminal conditioning and run/direction command decoder.
// Assumes pins from switches outside the clock domain and a plain register port.
`timescale 1ns/1ps
module tdr_decoder import tdr_pkg::*; #(
    parameter int DLY_CYC = DLY_UNIT_CYC,   // Cycles per 0.1 s delay step
    parameter int STEP_CYC = RAMP_STEP_CYC  // Cycles per 1 ms ramp step
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire tdr_bus_req_s bus_req,       // Register port request
    output logic [15:0] bus_rdata,          // Read data, cycle after strobe
    input wire logic [N_IN-1:0] term_closed, // Pin high while tied to return
    output tdr_cmd_s run_cmd,               // Registered run/direction
    output logic [31:0] freq_offset         // Up/down offset, micro-Hz steps
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rst_sync_q; // Asserts at once, releases after two edges
    logic rst_ok_n;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_ok_n = rst_sync_q[1];

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [1:0] mode_q, mode_d;
    logic [15:0] rate_q, rate_d;
    logic [1:0] res_q, res_d;
    logic [N_IN-1:0] lvl_sel_q, lvl_sel_d;              // One bit per input
    logic [N_DLY-1:0][14:0] on_dly_q, on_dly_d;
    logic [N_DLY-1:0][14:0] off_dly_q, off_dly_d;
    logic [15:0] rdata_q, rdata_d;
    logic [N_IN-1:0] cond;                              // Conditioned levels
    logic [31:0] freq_q;
    tdr_cmd_s cmd_q;
    logic [14:0] wval;                                  // Clamped delay value

    // Write decode and read mux
    always_comb begin
        mode_d = mode_q;
        rate_d = rate_q;
        res_d = res_q;
        lvl_sel_d = lvl_sel_q;
        on_dly_d = on_dly_q;
        off_dly_d = off_dly_q;
        rdata_d = 16'h0000; // Unmapped or idle reads give zero
        // Out-of-range delays saturate rather than wrap
        wval = (bus_req.wdata[14:0] > DLY_MAX || bus_req.wdata[15]) ? DLY_MAX : bus_req.wdata[14:0];
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                REG_MODE: mode_d = bus_req.wdata[1:0];
                REG_RATE: rate_d = bus_req.wdata;
                REG_RES: res_d = bus_req.wdata[1:0];
                REG_LVL_LO: lvl_sel_d[4:0] = bus_req.wdata[4:0];
                REG_LVL_HI: lvl_sel_d[9:5] = bus_req.wdata[4:0];
                default: begin
                    for (int i = 0; i < N_DLY; i++) begin
                        if (bus_req.addr == REG_ON_BASE + 5'(i)) on_dly_d[i] = wval;
                        if (bus_req.addr == REG_OFF_BASE + 5'(i)) off_dly_d[i] = wval;
                    end
                end
            endcase
        end
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                REG_MODE: rdata_d = {14'h0000, mode_q};
                REG_RATE: rdata_d = rate_q;
                REG_RES: rdata_d = {14'h0000, res_q};
                REG_LVL_LO: rdata_d = {11'h000, lvl_sel_q[4:0]};
                REG_LVL_HI: rdata_d = {11'h000, lvl_sel_q[9:5]};
                REG_STATUS: rdata_d = {4'h0, cmd_q, cond};
                REG_FREQ_LO: rdata_d = freq_q[15:0];
                REG_FREQ_HI: rdata_d = freq_q[31:16];
                default: begin
                    for (int i = 0; i < N_DLY; i++) begin
                        if (bus_req.addr == REG_ON_BASE + 5'(i)) rdata_d = {1'b0, on_dly_q[i]};
                        if (bus_req.addr == REG_OFF_BASE + 5'(i)) rdata_d = {1'b0, off_dly_q[i]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            mode_q <= MODE_RST;
            rate_q <= RATE_RST;
            res_q <= RES_RST;
            lvl_sel_q <= {LVL_RST, LVL_RST};
            on_dly_q <= {N_DLY{DLY_RST}};
            off_dly_q <= {N_DLY{DLY_RST}};
            rdata_q <= 16'h0000;
        end else begin
            mode_q <= mode_d;
            rate_q <= rate_d;
            res_q <= res_d;
            lvl_sel_q <= lvl_sel_d;
            on_dly_q <= on_dly_d;
            off_dly_q <= off_dly_d;
            rdata_q <= rdata_d;
        end
    end
    assign bus_rdata = rdata_q;

    // ----------------------------------------
    // Pin synchroniser and level select
    // ----------------------------------------
    logic [N_IN-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;
    logic [N_IN-1:0] lvl; // Active-high level per input
    // A new pin level counts only once stages two and three agree
    always_comb begin
        pin_d = pin_q;
        for (int i = 0; i < N_IN; i++) begin
            if (s2_q[i] == s3_q[i]) pin_d[i] = s3_q[i];
        end
    end
    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pin_q <= '0;
        end else begin
            s1_q <= term_closed;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= pin_d;
        end
    end
    // Select 1: closed is active; select 0: open is active
    assign lvl = (pin_q & lvl_sel_q) | (~pin_q & ~lvl_sel_q);

    // ----------------------------------------
    // ON/OFF delay on the first five inputs
    // ----------------------------------------
    logic [24:0] pre_q, pre_d;                   // 0.1 s prescaler
    logic tick;
    logic [N_DLY-1:0] filt_q, filt_d;
    logic [N_DLY-1:0][14:0] cnt_q, cnt_d;
    // Free-running prescaler: a delay may end up to one step early,
    // traded for a single shared divider instead of five.
    assign tick = (pre_q == 25'(DLY_CYC - 1));
    always_comb begin
        pre_d = tick ? 25'h0 : pre_q + 25'h1;
        filt_d = filt_q;
        cnt_d = cnt_q;
        for (int i = 0; i < N_DLY; i++) begin
            if (lvl[i] == filt_q[i]) begin
                cnt_d[i] = 15'h0000; // No pending change
            end else if (cnt_q[i] >= (lvl[i] ? on_dly_q[i] : off_dly_q[i])) begin
                filt_d[i] = lvl[i];
                cnt_d[i] = 15'h0000;
            end else if (tick) begin
                cnt_d[i] = cnt_q[i] + 15'h1;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            pre_q <= 25'h0;
            filt_q <= '0;
            cnt_q <= '0;
        end else begin
            pre_q <= pre_d;
            filt_q <= filt_d;
            cnt_q <= cnt_d;
        end
    end
    assign cond = {lvl[N_IN-1:N_DLY], filt_q};

    // ----------------------------------------
    // Run/direction decoder
    // ----------------------------------------
    logic [2:0] prev_q;     // Last conditioned levels of inputs one to three
    logic run_q, run_d;     // Latched run state for the three-wire modes
    tdr_cmd_s cmd_d;
    logic rise1, rise2;
    tdr_mode_e mode;
    assign mode = tdr_mode_e'(mode_q);
    assign rise1 = cond[0] & ~prev_q[0];
    assign rise2 = cond[1] & ~prev_q[1];
    always_comb begin
        cmd_d = cmd_q;
        run_d = run_q;
        unique case (mode)
            TWO_WIRE_A: begin
                cmd_d.forward_run_command = cond[0] & ~cond[1];
                cmd_d.backward_run_command = ~cond[0] & cond[1];
                run_d = cond[0] ^ cond[1];
            end
            TWO_WIRE_B: begin
                cmd_d.forward_run_command = cond[0] & ~cond[1];
                cmd_d.backward_run_command = cond[0] & cond[1];
                run_d = cond[0];
            end
            THREE_WIRE_A: begin
                // Simultaneous presses cancel and the state holds
                if (!cond[2]) begin
                    cmd_d = '0;
                end else if (rise1 && !rise2) begin
                    cmd_d = 2'b10;
                end else if (rise2 && !rise1) begin
                    cmd_d = 2'b01;
                end
                run_d = cmd_d.forward_run_command | cmd_d.backward_run_command;
            end
            THREE_WIRE_B: begin
                if (!cond[2]) begin
                    run_d = 1'b0;
                end else if (rise1) begin
                    run_d = 1'b1;
                end
                cmd_d.forward_run_command = run_d & ~cond[1];
                cmd_d.backward_run_command = run_d & cond[1];
            end
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            prev_q <= 3'h0;
            run_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            prev_q <= cond[2:0];
            run_q <= run_d;
            cmd_q <= cmd_d;
        end
    end
    assign run_cmd = cmd_q;

    // ----------------------------------------
    // Up/down frequency ramp (inputs four and five)
    // ----------------------------------------
    logic [17:0] ms_q, ms_d;
    logic ms_tick;
    logic [31:0] step, freq_d;
    assign ms_tick = (ms_q == 18'(STEP_CYC - 1));
    // Rate in units/s applied every 1 ms gives the same units per ms / 1000
    assign step = (res_q == RES_COARSE) ? 32'(rate_q) * 32'h0000_000A : 32'(rate_q);
    always_comb begin
        ms_d = ms_tick ? 18'h0 : ms_q + 18'h1;
        freq_d = freq_q;
        if (ms_tick && cond[3] && !cond[4]) begin
            freq_d = (FREQ_MAX - freq_q < step) ? FREQ_MAX : freq_q + step;
        end else if (ms_tick && cond[4] && !cond[3]) begin
            freq_d = (freq_q < step) ? 32'h0 : freq_q - step;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            ms_q <= 18'h0;
            freq_q <= 32'h0;
        end else begin
            ms_q <= ms_d;
            freq_q <= freq_d;
        end
    end
    assign freq_offset = freq_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_ok_n);
    two_a_dir_a: assert property ((mode == TWO_WIRE_A && cond[0] != cond[1])
        |=> run_cmd == {$past(cond[0]), $past(cond[1])}) else $error("mode 0 direction wrong");
    two_a_stop_a: assert property ((mode == TWO_WIRE_A && cond[0] == cond[1])
        |=> run_cmd == 2'b00) else $error("mode 0 not stopped");
    two_b_dir_a: assert property ((mode == TWO_WIRE_B && cond[0])
        |=> run_cmd == {~$past(cond[1]), $past(cond[1])}) else $error("mode 1 direction wrong");
    two_b_stop_a: assert property ((mode == TWO_WIRE_B && !cond[0])
        |=> run_cmd == 2'b00) else $error("mode 1 not stopped");
    three_a_start_a: assert property ((mode == THREE_WIRE_A && cond[2] && rise2 && !rise1)
        |=> run_cmd == 2'b01) else $error("mode 2 reverse start missed");
    three_a_hold_a: assert property ((mode == THREE_WIRE_A && $past(mode) == THREE_WIRE_A
        && cond[2] && !rise1 && !rise2) |=> $stable(run_cmd)) else $error("mode 2 state lost");
    three_stop_a: assert property ((mode_q[1] && !cond[2])
        |=> run_cmd == 2'b00) else $error("enable off not stopped");
    three_b_start_a: assert property ((mode == THREE_WIRE_B && cond[2] && rise1)
        |=> run_cmd == {~$past(cond[1]), $past(cond[1])}) else $error("mode 3 start wrong");
    dly_zero_a: assert property ((lvl[0] != filt_q[0] && on_dly_q[0] == 15'h0 && off_dly_q[0] == 15'h0)
        |=> filt_q[0] == $past(lvl[0])) else $error("zero delay not immediate");
    ramp_up_a: assert property ((ms_tick && cond[3] && !cond[4] && freq_q < 32'h8000_0000)
        |=> freq_q == $past(freq_q) + $past(step)) else $error("ramp step wrong");
    forward_run_c: cover property (mode == THREE_WIRE_A && run_cmd == 2'b10);
    backward_run_c: cover property (mode == THREE_WIRE_B && run_cmd == 2'b01);
    dly_wait_c: cover property (cnt_q[0] == 15'h0002);
endmodule

// File: include/tdr_pkg.sv
// Shared constants and types for the terminal run command decoder.
// Assumes a 200 MHz system clock and a one-cycle-read register port.
package tdr_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 32'h0000_1388;                 // 200 MHz
    localparam longint DLY_UNIT_PS = 64'h0000_0017_4876_E800;     // 0.1 s delay unit
    localparam longint RAMP_STEP_PS = 64'h0000_0000_3B9A_CA00;    // 1 ms ramp step
    localparam int DLY_UNIT_CYC = int'(DLY_UNIT_PS / CLK_PERIOD_PS);
    localparam int RAMP_STEP_CYC = int'(RAMP_STEP_PS / CLK_PERIOD_PS);
    // ----------------------------------------
    // Register map (word index)
    // ----------------------------------------
    localparam logic [4:0] REG_MODE = 5'h00;      // terminal_command_mode_sel
    localparam logic [4:0] REG_RATE = 5'h01;      // ramp_adjust_rate
    localparam logic [4:0] REG_RES = 5'h02;       // freq_reference_resolution
    localparam logic [4:0] REG_LVL_LO = 5'h03;    // level_select_low_group
    localparam logic [4:0] REG_LVL_HI = 5'h04;    // level_select_high_group
    localparam logic [4:0] REG_ON_BASE = 5'h05;   // input_on_delay, 5 words
    localparam logic [4:0] REG_OFF_BASE = 5'h0A;  // input_off_delay, 5 words
    localparam logic [4:0] REG_STATUS = 5'h0F;
    localparam logic [4:0] REG_FREQ_LO = 5'h10;
    localparam logic [4:0] REG_FREQ_HI = 5'h11;
    // ----------------------------------------
    // Reset values and limits
    // ----------------------------------------
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [15:0] RATE_RST = 16'h03E8;  // 1.000 Hz/s
    localparam logic [1:0] RES_RST = 2'h2;
    localparam logic [1:0] RES_COARSE = 2'h1;
    localparam logic [4:0] LVL_RST = 5'h00;
    localparam logic [14:0] DLY_RST = 15'h0000;
    localparam logic [14:0] DLY_MAX = 15'h7530;   // 3000.0 s
    localparam logic [31:0] FREQ_MAX = 32'hFFFF_FFFF;
    localparam int N_IN = 10;
    localparam int N_DLY = 5;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {TWO_WIRE_A, TWO_WIRE_B, THREE_WIRE_A, THREE_WIRE_B} tdr_mode_e;
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tdr_bus_req_s;
    typedef struct packed {
        logic forward_run_command;
        logic backward_run_command;
    } tdr_cmd_s;
endpackage

// File: tb/tdr_switch_bank.sv
// Behavioural bank of switches and pushbuttons wired to the input terminals.
// Assumes the bench says which inputs should read active and which level select is set.
`timescale 1ns/1ps
module tdr_switch_bank (
    input wire logic sys_clk,
    input wire logic [9:0] want_active, // Inputs the operator wants active
    input wire logic [9:0] level_sel,   // Level select now set in the device
    output logic [9:0] term_closed      // Contact state at the pins
);
    // ----------------------------------------
    // Contacts
    // ----------------------------------------
    // Contacts settle on the first edge, well inside reset, so no unknown reaches the device
    // Contacts move one edge after the operator, changing on the clock edge itself
    always @(posedge sys_clk) begin
        // Select 1 closes the contact for active, select 0 opens it
        term_closed <= want_active ~^ level_sel;
    end
endmodule

// File: tb/terminal_run_command_decoder_test.sv
// Self-checking bench for the terminal run command decoder.
// Assumes the switch bank model and short delay and ramp counts.
`timescale 1ns/1ps
module terminal_run_command_decoder_test;
    import tdr_pkg::*;
    // ----------------------------------------
    // Signals and tables
    // ----------------------------------------
    logic sys_clk;
    logic rst_n;
    tdr_bus_req_s req;        // Register port request
    logic [15:0] bus_rdata;
    logic [9:0] act;          // Wanted active inputs
    logic [9:0] sel;          // Copy of the level select
    logic [9:0] pins;
    tdr_cmd_s run_cmd;
    logic [31:0] freq_offset;
    logic [31:0] f0;          // Offset at the start of a ramp window
    int fails;
    int comparisons;
    // Three-wire sequences: enable is bit 2, held for the first five steps and dropped for the last three
    localparam logic [9:0] M2_ACT [8] = '{10'h004, 10'h005, 10'h004, 10'h006, 10'h004, 10'h000, 10'h001, 10'h000};
    localparam logic [1:0] M2_CMD [8] = '{2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
    localparam logic [9:0] M3_ACT [8] = '{10'h004, 10'h005, 10'h004, 10'h006, 10'h004, 10'h000, 10'h001, 10'h000};
    localparam logic [1:0] M3_CMD [8] = '{2'h0, 2'h2, 2'h2, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0};
    // ----------------------------------------
    // Design and far side
    // ----------------------------------------
    // Short counts keep delays and ramp steps to a few cycles
    tdr_decoder #(.DLY_CYC(4), .STEP_CYC(8)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(req),
        .bus_rdata(bus_rdata), .term_closed(pins), .run_cmd(run_cmd), .freq_offset(freq_offset));
    tdr_switch_bank bank (.sys_clk(sys_clk), .want_active(act), .level_sel(sel), .term_closed(pins));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expect_v);
        comparisons++;
        if (seen !== expect_v) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, expect_v, seen);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // One-cycle write strobe
    task automatic bus_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there
    task automatic bus_read_check(input string what, input logic [4:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1;
        check(what, {16'h0000, bus_rdata}, {16'h0000, e});
    endtask
    task automatic put(input logic [9:0] v);
        @(posedge sys_clk);
        act <= v;
    endtask
    // Drive, wait past the sync and decode pipeline, compare the command
    task automatic step(input string what, input logic [9:0] v, input logic [1:0] e);
        put(v);
        settle(12);
        #1;
        check(what, {30'h0, run_cmd}, {30'h0, e});
    endtask
    // Offset change over exactly ten ramp steps
    task automatic ramp_check(input string what, input logic up, input logic [31:0] e);
        settle(20);
        #1;
        f0 = freq_offset;
        settle(80);
        #1;
        check(what, up ? freq_offset - f0 : f0 - freq_offset, e);
    endtask
    // ----------------------------------------
    // Clock, watchdog
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // The ceiling ramp needs about 55200 cycles in all, so this only trips on a hang
    initial begin
        repeat (70000) @(posedge sys_clk);
        fails++;
        end_of_test();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        req = '0;
        act = 10'h000;
        sel = 10'h000;
        fails = 0;
        comparisons = 0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle(4);
        // Reset values, unmapped read, closed pins inactive under select 0
        bus_read_check("mode", REG_MODE, 16'h0000);
        bus_read_check("rate", REG_RATE, 16'h03E8);
        bus_read_check("resolution", REG_RES, 16'h0002);
        bus_read_check("level low", REG_LVL_LO, 16'h0000);
        bus_read_check("level high", REG_LVL_HI, 16'h0000);
        bus_read_check("off delay", REG_OFF_BASE, 16'h0000);
        bus_read_check("unmapped", 5'h1F, 16'h0000);
        bus_read_check("status closed", REG_STATUS, 16'h0000);
        step("open pin", 10'h020, 2'h0);
        bus_read_check("status open", REG_STATUS, 16'h0020);
        // Select 1 everywhere
        put(10'h000);
        bus_write(REG_LVL_LO, 16'h001F);
        bus_write(REG_LVL_HI, 16'h001F);
        sel <= 10'h3FF;
        // Two-wire tables over all four states of inputs one and two
        for (int i = 0; i < 4; i++) begin
            step("mode 0", {8'h00, i[1:0]}, {i[0] & ~i[1], ~i[0] & i[1]});
        end
        bus_write(REG_MODE, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            step("mode 1", {8'h00, i[1:0]}, {i[0] & ~i[1], i[0] & i[1]});
        end
        step("stop", 10'h000, 2'h0);
        // Three-wire sequences, presses remembered until the next action
        bus_write(REG_MODE, 16'h0002);
        for (int i = 0; i < 8; i++) begin
            step("mode 2", M2_ACT[i], M2_CMD[i]);
        end
        bus_write(REG_MODE, 16'h0003);
        for (int i = 0; i < 8; i++) begin
            step("mode 3", M3_ACT[i], M3_CMD[i]);
        end
        // Delays on input 1 only; input 6 passes straight through
        bus_write(REG_MODE, 16'h0000);
        bus_write(REG_ON_BASE, 16'hFFFF);
        bus_read_check("on delay max", REG_ON_BASE, 16'h7530);
        bus_write(REG_ON_BASE, 16'h0005);
        bus_write(REG_OFF_BASE, 16'h0005);
        put(10'h021);
        settle(8);
        bus_read_check("on early", REG_STATUS, 16'h0020);
        settle(1);
        #1;
        check("read idle", {16'h0000, bus_rdata}, 32'h0000_0000);
        settle(30);
        bus_read_check("on late", REG_STATUS, 16'h0821);
        put(10'h020);
        settle(8);
        bus_read_check("off early", REG_STATUS, 16'h0821);
        settle(30);
        bus_read_check("off late", REG_STATUS, 16'h0020);
        // Up/down ramp at the default rate, fine and coarse
        put(10'h008);
        ramp_check("up fine", 1'b1, 32'h0000_2710);
        bus_write(REG_RES, 16'h0001);
        ramp_check("up coarse", 1'b1, 32'h0001_86A0);
        bus_write(REG_RES, 16'h0002);
        put(10'h010);
        ramp_check("down fine", 1'b0, 32'h0000_2710);
        bus_write(REG_RES, 16'h0001);
        settle(300);
        #1;
        check("offset floor", freq_offset, 32'h0000_0000);
        bus_read_check("offset low", REG_FREQ_LO, 16'h0000);
        // Top rate, coarse: ten steps of 655.35 Hz/s, then run into the ceiling
        bus_write(REG_RATE, 16'hFFFF);
        bus_read_check("rate max", REG_RATE, 16'hFFFF);
        put(10'h008);
        ramp_check("up max rate", 1'b1, 32'h0063_FF9C);
        settle(54000);
        bus_read_check("offset high", REG_FREQ_HI, 16'hFFFF);
        check("offset ceiling", freq_offset, 32'hFFFF_FFFF);
        end_of_test();
    end
endmodule
